// file: standard_timer_regs.svh
`ifndef STANDARD_TIMER_REGS_SVH
`define STANDARD_TIMER_REGS_SVH

// Byte addresses on the register bus
`define ADDR_TIMER_CONTROL_0 5'h00
`define ADDR_TIMER_CONTROL_1 5'h04
`define ADDR_COUNTER_LOW 5'h08
`define ADDR_COUNTER_HIGH 5'h0C
`define ADDR_COMPARE_A_LOW 5'h10
`define ADDR_COMPARE_A_HIGH 5'h14

// Control register 0 fields
`define CTRL0_PAUSE_BIT 7
`define CTRL0_CLKSEL_MSB 6
`define CTRL0_CLKSEL_LSB 4
`define CTRL0_RUN_BIT 3
`define CTRL0_PERIOD_MSB 2
`define CTRL0_PERIOD_LSB 0

// Control register 1 fields
`define CTRL1_MODE_MSB 7
`define CTRL1_MODE_LSB 6
`define CTRL1_FUNC_MSB 5
`define CTRL1_FUNC_LSB 4
`define CTRL1_INIT_BIT 3
`define CTRL1_INVERT_BIT 2
`define CTRL1_SWAP_BIT 1
`define CTRL1_CLRSEL_BIT 0

// Reset values
`define TIMER_CONTROL_0_RESET 8'h00
`define TIMER_CONTROL_1_RESET 8'h00
`define COMPARE_A_RESET 10'h000
`define COUNTER_RESET 10'h000

// Prescaler terminal counts and counter limits
`define PRESCALE_WIDTH 6
`define PRESCALE_DIV4_LAST 2'h3
`define PRESCALE_DIV16_LAST 4'hF
`define PRESCALE_DIV64_LAST 6'h3F
`define COUNTER_MAX 10'h3FF
`define PERIOD_OVERFLOW_CLOCKS 11'h400

`endif

// file: standard_timer_pkg.sv
package standard_timer_pkg;

  typedef enum logic [1:0] {
    MODE_COMPARE,
    MODE_CAPTURE,
    MODE_PWM,
    MODE_TIMER
  } mode_t;

  typedef enum logic [2:0] {
    CLK_SYS_DIV4,
    CLK_SYS,
    CLK_HIGH_DIV16,
    CLK_HIGH_DIV64,
    CLK_TIME_BASE_A,
    CLK_TIME_BASE_B,
    CLK_EXT_RISE,
    CLK_EXT_FALL
  } clk_sel_t;

  typedef enum logic [1:0] {
    FUNC_0,
    FUNC_1,
    FUNC_2,
    FUNC_3
  } func_t;

endpackage

// file: timer_tick_if.sv
`timescale 1ns/1ps
interface timer_tick_if;
  logic enable;
  logic [2:0] clockSel;
  logic tick;
  logic extRise;

  modport source (input enable, input clockSel, output tick, output extRise);
  modport sink (output enable, output clockSel, input tick, input extRise);
endinterface // timer_tick_if

// file: timer_clock_source.sv
`timescale 1ns/1ps
`include "standard_timer_regs.svh"
module timer_clock_source (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic externalClockPin, // Raw external clock pin
  input wire logic timeBaseClock, // Time-base clock from another domain
  timer_tick_if.source tickBus // Tick and select
);
  logic [`PRESCALE_WIDTH-1:0] prescale;
  logic [2:0] syncReg [2];
  logic [1:0] stable;
  logic [1:0] agree;
  logic [1:0] rise;
  logic [1:0] fall;
  logic sel;

  always_ff @(posedge clk) begin
    if (rst) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 1'b1;
    end
  end

  // Slot 0 is the external pin, slot 1 the time-base clock
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge clk) begin
      if (rst) begin
        syncReg[i] <= 3'h0;
        stable[i] <= 1'b0;
      end else begin
        syncReg[i] <= {syncReg[i][1:0], (i == 0) ? externalClockPin : timeBaseClock};
        if (agree[i]) begin
          stable[i] <= syncReg[i][2];
        end
      end
    end
    assign agree[i] = syncReg[i][2] == syncReg[i][1];
    // One edge per settled change, so a pin edge counts exactly once
    assign rise[i] = agree[i] && syncReg[i][2] && !stable[i];
    assign fall[i] = agree[i] && !syncReg[i][2] && stable[i];
  end

  always_comb begin
    unique case (standard_timer_pkg::clk_sel_t'(tickBus.clockSel))
      standard_timer_pkg::CLK_SYS_DIV4: sel = prescale[1:0] == `PRESCALE_DIV4_LAST;
      standard_timer_pkg::CLK_SYS: sel = 1'b1;
      // High clock is taken as the system clock here
      standard_timer_pkg::CLK_HIGH_DIV16: sel = prescale[3:0] == `PRESCALE_DIV16_LAST;
      standard_timer_pkg::CLK_HIGH_DIV64: sel = prescale == `PRESCALE_DIV64_LAST;
      standard_timer_pkg::CLK_TIME_BASE_A: sel = rise[1];
      standard_timer_pkg::CLK_TIME_BASE_B: sel = rise[1];
      standard_timer_pkg::CLK_EXT_RISE: sel = rise[0];
      standard_timer_pkg::CLK_EXT_FALL: sel = fall[0];
    endcase
  end

  assign tickBus.tick = tickBus.enable && sel;
  assign tickBus.extRise = rise[0];
endmodule // timer_clock_source

// file: standard_timer.sv
`timescale 1ns/1ps
`include "standard_timer_regs.svh"
module standard_timer (
  input wire logic clk, // System clock, 50 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [4:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic externalClockPin, // External clock input
  input wire logic timeBaseClock, // Time-base clock input
  input wire logic capturePin, // Capture input
  output logic timerOutputPin, // Output pin level
  output logic timerOutputEnable, // Output pin drive enable
  output logic compareAEvent, // Comparator A event pulse
  output logic comparePEvent // Comparator P event pulse
);
  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic [9:0] count;
  logic [9:0] compareA;
  logic [7:0] lowBuffer;
  logic runPrev;
  logic outLevel;
  logic [2:0] capSync;
  logic capStable;

  logic runEnable;
  logic pause;
  logic [2:0] period;
  standard_timer_pkg::mode_t mode;
  standard_timer_pkg::func_t func;
  logic initLevel;
  logic invert;
  logic swap;
  logic clearSel;
  logic runRise;
  logic tick;
  logic matchA;
  logic matchP;
  logic clearNow;
  logic aFlagOk;
  logic pFlagOk;
  logic singlePulse;
  logic outputMode;
  logic [10:0] dutyValue;
  logic pwmActive;
  logic capAgree;
  logic capRise;
  logic capFall;
  logic capEvent;
  logic request;
  logic accept;
  logic [31:0] next_readdata;

  timer_tick_if tickBus ();

  timer_clock_source u_clock_source (
    .clk(clk),
    .rst(rst),
    .externalClockPin(externalClockPin),
    .timeBaseClock(timeBaseClock),
    .tickBus(tickBus.source)
  );

  assign runEnable = ctrl0[`CTRL0_RUN_BIT];
  assign pause = ctrl0[`CTRL0_PAUSE_BIT];
  assign period = ctrl0[`CTRL0_PERIOD_MSB:`CTRL0_PERIOD_LSB];
  assign mode = standard_timer_pkg::mode_t'(ctrl1[`CTRL1_MODE_MSB:`CTRL1_MODE_LSB]);
  assign func = standard_timer_pkg::func_t'(ctrl1[`CTRL1_FUNC_MSB:`CTRL1_FUNC_LSB]);
  assign initLevel = ctrl1[`CTRL1_INIT_BIT];
  assign invert = ctrl1[`CTRL1_INVERT_BIT];
  assign swap = ctrl1[`CTRL1_SWAP_BIT];
  assign clearSel = ctrl1[`CTRL1_CLRSEL_BIT];

  // Off or paused gates the tick, which also stands in for power-down
  assign tickBus.enable = runEnable && !pause;
  assign tickBus.clockSel = ctrl0[`CTRL0_CLKSEL_MSB:`CTRL0_CLKSEL_LSB];
  assign tick = tickBus.tick;

  assign runRise = runEnable && !runPrev;
  assign singlePulse = mode == standard_timer_pkg::MODE_PWM && func == standard_timer_pkg::FUNC_3;
  assign outputMode = mode == standard_timer_pkg::MODE_COMPARE
    || mode == standard_timer_pkg::MODE_PWM;

  // Comparators
  assign matchA = count == compareA;
  // Period zero compares as the overflow point, giving 1024 clocks
  assign matchP = (period == 3'h0) ? (count == `COUNTER_MAX)
    : (count == {period, 7'h00});

  always_comb begin
    unique case (mode)
      standard_timer_pkg::MODE_COMPARE,
      standard_timer_pkg::MODE_TIMER: begin
        clearNow = clearSel ? (matchA && compareA != 10'h000) : matchP;
      end
      standard_timer_pkg::MODE_PWM: begin
        clearNow = !singlePulse && (swap ? matchA : matchP);
      end
      standard_timer_pkg::MODE_CAPTURE: begin
        clearNow = 1'b0;
      end
    endcase
  end

  // Compare A of zero never flags in compare and timer modes
  assign aFlagOk = !(compareA == 10'h000 && (mode == standard_timer_pkg::MODE_COMPARE
    || mode == standard_timer_pkg::MODE_TIMER));
  assign pFlagOk = !singlePulse && !(clearSel && (mode == standard_timer_pkg::MODE_COMPARE
    || mode == standard_timer_pkg::MODE_TIMER));

  // Duty threshold; eleven bits so a 1024 duty is reachable
  assign dutyValue = swap ? ((period == 3'h0) ? `PERIOD_OVERFLOW_CLOCKS
    : {1'b0, period, 7'h00}) : {1'b0, compareA};
  assign pwmActive = {1'b0, count} < dutyValue;

  always_ff @(posedge clk) begin
    if (rst) begin
      runPrev <= 1'b0;
    end else begin
      runPrev <= runEnable;
    end
  end

  // Counter
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= `COUNTER_RESET;
    end else if (runRise) begin
      count <= `COUNTER_RESET;
    end else if (tick) begin
      if (clearNow) begin
        count <= `COUNTER_RESET;
      end else begin
        count <= count + 10'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      compareAEvent <= 1'b0;
      comparePEvent <= 1'b0;
    end else begin
      compareAEvent <= tick && matchA && aFlagOk;
      comparePEvent <= tick && matchP && pFlagOk;
    end
  end

  // Capture pin: three stages, a change is taken once the last two agree
  always_ff @(posedge clk) begin
    if (rst) begin
      capSync <= 3'h0;
      capStable <= 1'b0;
    end else begin
      capSync <= {capSync[1:0], capturePin};
      if (capAgree) begin
        capStable <= capSync[2];
      end
    end
  end

  assign capAgree = capSync[2] == capSync[1];
  assign capRise = capAgree && capSync[2] && !capStable;
  assign capFall = capAgree && !capSync[2] && capStable;

  always_comb begin
    unique case (func)
      standard_timer_pkg::FUNC_0: capEvent = capRise;
      standard_timer_pkg::FUNC_1: capEvent = capFall;
      standard_timer_pkg::FUNC_2: capEvent = capRise || capFall;
      standard_timer_pkg::FUNC_3: capEvent = 1'b0;
    endcase
  end

  // Output level before inversion
  always_ff @(posedge clk) begin
    if (rst) begin
      outLevel <= 1'b0;
    end else if (runRise && outputMode) begin
      outLevel <= initLevel;
    end else if (mode == standard_timer_pkg::MODE_COMPARE) begin
      if (tick && matchA && aFlagOk) begin
        unique case (func)
          standard_timer_pkg::FUNC_0: outLevel <= outLevel;
          standard_timer_pkg::FUNC_1: outLevel <= 1'b0;
          standard_timer_pkg::FUNC_2: outLevel <= 1'b1;
          standard_timer_pkg::FUNC_3: outLevel <= !outLevel;
        endcase
      end
    end else if (mode == standard_timer_pkg::MODE_PWM) begin
      unique case (func)
        standard_timer_pkg::FUNC_0: outLevel <= !initLevel;
        standard_timer_pkg::FUNC_1: outLevel <= initLevel;
        standard_timer_pkg::FUNC_2: begin
          if (runEnable) begin
            outLevel <= pwmActive ? initLevel : !initLevel;
          end
        end
        standard_timer_pkg::FUNC_3: begin
          if (!runEnable || (tick && matchA)) begin
            outLevel <= !initLevel;
          end
        end
      endcase
    end
  end

  // Pin is registered, so it trails the internal level by one clock
  always_ff @(posedge clk) begin
    if (rst) begin
      timerOutputPin <= 1'b0;
      timerOutputEnable <= 1'b0;
    end else begin
      timerOutputPin <= outLevel ^ invert;
      timerOutputEnable <= outputMode;
    end
  end

  // Register bus: one wait cycle on every access
  assign request = avs_read || avs_write;
  assign accept = request && !avs_waitrequest;

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(request && avs_waitrequest);
    end
  end

  always_comb begin
    next_readdata = 32'h0000_0000;
    unique case (avs_address)
      `ADDR_TIMER_CONTROL_0: next_readdata = {24'h00_0000, ctrl0};
      `ADDR_TIMER_CONTROL_1: next_readdata = {24'h00_0000, ctrl1};
      `ADDR_COUNTER_LOW: next_readdata = {24'h00_0000, lowBuffer};
      `ADDR_COUNTER_HIGH: next_readdata = {30'h0000_0000, count[9:8]};
      `ADDR_COMPARE_A_LOW: next_readdata = {24'h00_0000, lowBuffer};
      `ADDR_COMPARE_A_HIGH: next_readdata = {30'h0000_0000, compareA[9:8]};
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  // Read data and buffer capture share the first request cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lowBuffer <= 8'h00;
    end else if (avs_read && avs_waitrequest && avs_address == `ADDR_COUNTER_HIGH) begin
      lowBuffer <= count[7:0];
    end else if (avs_read && avs_waitrequest && avs_address == `ADDR_COMPARE_A_HIGH) begin
      lowBuffer <= compareA[7:0];
    end else if (accept && avs_write && avs_address == `ADDR_COMPARE_A_LOW) begin
      lowBuffer <= avs_writedata[7:0];
    end
  end

  // Capture wins over a same-cycle software write
  always_ff @(posedge clk) begin
    if (rst) begin
      compareA <= `COMPARE_A_RESET;
    end else if (mode == standard_timer_pkg::MODE_CAPTURE && runEnable && capEvent) begin
      compareA <= count;
    end else if (accept && avs_write && avs_address == `ADDR_COMPARE_A_HIGH) begin
      compareA <= {avs_writedata[1:0], lowBuffer};
    end
  end

  // Hardware run changes follow the software write so they win
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl0 <= `TIMER_CONTROL_0_RESET;
    end else begin
      if (accept && avs_write && avs_address == `ADDR_TIMER_CONTROL_0) begin
        ctrl0 <= avs_writedata[7:0];
      end
      if (singlePulse && tickBus.extRise) begin
        ctrl0[`CTRL0_RUN_BIT] <= 1'b1;
      end
      if (singlePulse && tick && matchA) begin
        ctrl0[`CTRL0_RUN_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl1 <= `TIMER_CONTROL_1_RESET;
    end else if (accept && avs_write && avs_address == `ADDR_TIMER_CONTROL_1) begin
      ctrl1 <= avs_writedata[7:0];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_run_rise_clear;
    runRise |=> count == 10'h000;
  endproperty
  a_run_rise_clear: assert property (p_run_rise_clear) else $error("count not cleared on run");

  property p_off_hold;
    !runEnable |=> count == $past(count);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("count moved while off");

  property p_pause_hold;
    (pause && !runRise) |=> count == $past(count);
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("count moved while paused");

  property p_count_inc;
    (tick && !runRise && !clearNow) |=> count == 10'($past(count) + 10'h001);
  endproperty
  a_count_inc: assert property (p_count_inc) else $error("count did not advance");

  property p_clear_hold;
    (tick && clearNow && !runRise) |=> count == 10'h000;
  endproperty
  a_clear_hold: assert property (p_clear_hold) else $error("match did not clear count");

  // Grid point taken from the rule, not from the comparator
  property p_period_grid;
    (tick && !runRise && !clearSel && period != 3'h0 && count[9:7] == period
      && count[6:0] == 7'h00 && (mode == standard_timer_pkg::MODE_COMPARE
      || mode == standard_timer_pkg::MODE_TIMER)) |=> count == 10'h000;
  endproperty
  a_period_grid: assert property (p_period_grid) else $error("period match off grid");

  property p_pin_init;
    (runRise && outputMode) |=> outLevel == $past(initLevel) ##1
      timerOutputPin == ($past(initLevel, 2) ^ $past(invert));
  endproperty
  a_pin_init: assert property (p_pin_init) else $error("pin not at initial level");

  property p_timer_undriven;
    (mode == standard_timer_pkg::MODE_TIMER) |=> !timerOutputEnable;
  endproperty
  a_timer_undriven: assert property (p_timer_undriven) else $error("pin driven in timer mode");

  property p_counter_read;
    (avs_read && avs_waitrequest && avs_address == `ADDR_COUNTER_HIGH) |=>
      avs_readdata == {30'h0000_0000, $past(count[9:8])} && lowBuffer == $past(count[7:0]);
  endproperty
  a_counter_read: assert property (p_counter_read) else $error("counter high read wrong");

  property p_compare_write;
    (accept && avs_write && avs_address == `ADDR_COMPARE_A_HIGH
      && mode != standard_timer_pkg::MODE_CAPTURE) |=>
      compareA == {$past(avs_writedata[1:0]), $past(lowBuffer)};
  endproperty
  a_compare_write: assert property (p_compare_write) else $error("compare A not latched");

  property p_wait_one;
    (request && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer timing wrong");

  c_period_clear: cover property (tick && matchP && clearNow);
  c_pwm_run: cover property (mode == standard_timer_pkg::MODE_PWM && runEnable && tick);
  c_capture: cover property (mode == standard_timer_pkg::MODE_CAPTURE && capEvent);
  c_toggle: cover property (mode == standard_timer_pkg::MODE_COMPARE && compareAEvent);
endmodule // standard_timer

// file: far_side_model.sv
`timescale 1ns/1ps
module far_side_model (
  input wire logic clk, // System clock
  input wire logic pinOut, // Timer output level
  input wire logic pinEnable, // Timer output enable
  output logic externalClockPin, // Event clock
  output logic capturePin, // Capture input
  output logic timeBaseClock, // Slow tick clock
  output logic pinLevel // Level seen on the wire
);
  logic [2:0] tbCount;
  initial begin
    externalClockPin = 1'b0;
    capturePin = 1'b0;
    timeBaseClock = 1'b0;
    pinLevel = 1'b0;
    tbCount = 3'h0;
  end
  // Half period of five clocks
  always @(posedge clk) begin
    tbCount <= (tbCount == 3'h4) ? 3'h0 : tbCount + 3'h1;
    if (tbCount == 3'h4) begin
      timeBaseClock <= ~timeBaseClock;
    end
  end
  // Undriven wire keeps no level, so it flips every cycle
  always @(posedge clk) begin
    pinLevel <= pinEnable ? pinOut : ~pinLevel;
  end
  // Each level held four clocks so the synchroniser sees every edge
  task automatic pulse(input int n);
    repeat (n) begin
      externalClockPin <= 1'b1;
      repeat (4) @(posedge clk);
      externalClockPin <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask
  task automatic flip();
    capturePin <= ~capturePin;
    repeat (8) @(posedge clk);
  endtask
endmodule // far_side_model

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk;
  logic rst;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, externalClockPin, timeBaseClock, capturePin;
  logic timerOutputPin, timerOutputEnable, compareAEvent, comparePEvent, pinLevel;
  int miscompares = 0;
  int checks_done = 0;
  int g;
  logic [7:0] q;
  logic [7:0] tc0 [8] = '{8'h19, 8'h18, 8'h09, 8'h29, 8'h39, 8'h49, 8'h59, 8'h19};
  int tg [8] = '{129, 1024, 516, 2064, 8256, 1290, 1290, 11};
  logic [7:0] oc1 [5] = '{8'h08, 8'h18, 8'h28, 8'h38, 8'h3C};
  logic [4:0] os = 5'b01111;
  logic [4:0] oe = 5'b10101;
  logic [7:0] pc1 [5] = '{8'hA9, 8'hAC, 8'h88, 8'h98, 8'hAA};
  int pw [5] = '{32, 97, 0, 129, 129};
  always #10 clk = ~clk;
  standard_timer dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .externalClockPin(externalClockPin),
    .timeBaseClock(timeBaseClock), .capturePin(capturePin), .timerOutputPin(timerOutputPin),
    .timerOutputEnable(timerOutputEnable), .compareAEvent(compareAEvent),
    .comparePEvent(comparePEvent));
  far_side_model ext (.clk(clk), .pinOut(timerOutputPin), .pinEnable(timerOutputEnable),
    .externalClockPin(externalClockPin), .capturePin(capturePin),
    .timeBaseClock(timeBaseClock), .pinLevel(pinLevel));
  task automatic end_of_test();
    if (miscompares == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, s);
    end
  endtask
  // Outputs are registered, so values read just after a rise are the ones that rise sampled
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      end_of_test();
    end
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input string nm, input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, {24'h0, q});
  endtask
  task automatic wr_a(input logic [9:0] v);
    wr(5'h10, v[7:0]);
    wr(5'h14, {6'h00, v[9:8]});
  endtask
  task automatic cnt(input logic [9:0] v);
    rc("count high", 5'h0C, {6'h00, v[9:8]});
    rc("count low", 5'h08, v[7:0]);
  endtask
  // Second spacing only: the first follows the start, not a clear
  task automatic gap(input logic a, output int c);
    repeat (2) begin
      c = 0;
      do begin
        @(negedge clk);
        c++;
      end while ((a ? compareAEvent : comparePEvent) !== 1'b1 && c < 9000);
    end
    if (c >= 9000) begin
      miscompares++;
      end_of_test();
    end
    @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      rc("reset value", 5'(i * 4), 8'h00);
    end
    wr(5'h04, 8'hA5);
    rc("control 1", 5'h04, 8'hA5);
    wr(5'h04, 8'h00);
    wr(5'h08, 8'hFF);
    cnt(10'h000);
    wr(5'h10, 8'h5A);
    wr(5'h14, 8'hFF);
    rc("compare high", 5'h14, 8'h03);
    rc("compare low", 5'h10, 8'h5A);
    for (int i = 0; i < 8; i++) begin
      wr(5'h00, 8'h00);
      wr(5'h04, (i == 7) ? 8'hC1 : 8'hC0);
      wr_a((i == 7) ? 10'h00A : 10'h000);
      wr(5'h00, tc0[i]);
      gap(i == 7, g);
      chk("event spacing", tg[i], g);
      chk("pin enable", 32'h0, {31'h0, timerOutputEnable});
    end
    wr(5'h00, 8'h60);
    wr(5'h00, 8'h68);
    cnt(10'h000);
    ext.pulse(5);
    cnt(10'h005);
    wr(5'h00, 8'hE8);
    ext.pulse(3);
    cnt(10'h005);
    wr(5'h00, 8'h68);
    ext.pulse(2);
    cnt(10'h007);
    wr(5'h00, 8'h60);
    ext.pulse(2);
    cnt(10'h007);
    wr(5'h00, 8'h78);
    ext.pulse(4);
    cnt(10'h004);
    wr(5'h00, 8'h70);
    wr(5'h04, 8'h40);
    wr(5'h00, 8'h68);
    for (int i = 0; i < 4; i++) begin
      wr(5'h04, 8'h40 | 8'(i << 4));
      ext.pulse(2);
      ext.flip();
      rc("capture high", 5'h14, 8'h00);
      rc("capture low", 5'h10, (i == 3) ? 8'h06 : 8'(2 * i + 2));
    end
    wr_a(10'h002);
    for (int i = 0; i < 5; i++) begin
      wr(5'h00, 8'h60);
      wr(5'h04, oc1[i]);
      wr(5'h00, 8'h68);
      repeat (4) @(posedge clk);
      chk("start level", {31'h0, os[i]}, {31'h0, pinLevel});
      chk("pin enable", 32'h1, {31'h0, timerOutputEnable});
      ext.pulse(3);
      chk("match level", {31'h0, oe[i]}, {31'h0, pinLevel});
    end
    wr(5'h00, 8'h60);
    wr(5'h04, 8'hB8);
    wr(5'h00, 8'h68);
    repeat (4) @(posedge clk);
    chk("pulse lead", 32'h1, {31'h0, pinLevel});
    ext.pulse(3);
    chk("pulse trail", 32'h0, {31'h0, pinLevel});
    rc("run bit", 5'h00, 8'h60);
    wr_a(10'h020);
    for (int i = 0; i < 5; i++) begin
      wr(5'h00, 8'h10);
      wr(5'h04, pc1[i]);
      wr(5'h00, 8'h19);
      repeat (200) @(posedge clk);
      g = 0;
      repeat (129) begin
        @(negedge clk);
        g += (pinLevel === 1'b1);
      end
      @(posedge clk);
      chk("high cycles", pw[i], g);
    end
    end_of_test();
  end
endmodule // tb_top
